// >>> hdl/buffered_serial_port_pkg.sv
// Purpose: shared constants and types of the buffered serial port
// Assumes: APB slave with byte addresses, one 32-bit word per register
// Notes: offsets, the format reset value and some field positions live here
package buffered_serial_port_pkg;
  localparam logic [7:0] OFS_GLOBAL = 8'h00;
  localparam logic [7:0] OFS_FMT = 8'h04;
  localparam logic [7:0] OFS_DELAY = 8'h14;
  localparam logic [7:0] OFS_GROUP = 8'h18;
  localparam logic [7:0] OFS_BUFIDX = 8'h1C;
  localparam logic [7:0] OFS_BUFTX = 8'h20;
  localparam logic [7:0] OFS_BUFCTL = 8'h24;
  localparam logic [7:0] OFS_BUFRX = 8'h28;
  localparam logic [7:0] OFS_BUFSTAT = 8'h2C;
  localparam logic [7:0] OFS_RXHOLD = 8'h30;
  localparam logic [7:0] OFS_STATUS = 8'h34;
  localparam logic [7:0] OFS_GPIO = 8'h38;
  localparam int NUM_FMT = 4;
  localparam int GCR_CTRL = 0;
  localparam int GCR_EN = 1;
  localparam int FMT_PS = 8;
  localparam int FMT_PHASE = 16;
  localparam int FMT_POL = 17;
  localparam int FMT_HOLD = 18;
  localparam int GRP_LAST = 8;
  localparam int GRP_GO = 31;
  localparam int ST_OVR = 2;
  localparam int PIN_CLK = 0;
  localparam int PIN_COUT = 1;
  localparam int PIN_CIN = 2;
  localparam int PIN_SEL = 3;
  localparam logic [18:0] RST_FMT = 19'h0_0010;
  localparam logic [8:0] SETUP_BASE = 9'h002;
  localparam logic [8:0] SETUP_HOLD = 9'h003;
  localparam logic [4:0] WORD_MIN = 5'h02;
  localparam logic [4:0] WORD_MAX = 5'h10;
  localparam logic [3:0] OE_CTRL = 4'hB;
  localparam logic [15:0] STAT_DONE = 16'h0001;
  localparam logic [15:0] STAT_OVR = 16'h0002;
  typedef enum logic [2:0] {IDLE, LOAD, SETUP, SHIFT, STORE} phase_type;
  typedef struct packed {
    logic [15:0] tx;
    logic [15:0] rx;
    logic [15:0] ctl;
    logic [15:0] stat;
  } entry_type;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_type;
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } pin_drive_type;
  typedef struct packed {
    phase_type st;
    logic ctrl;
    logic en;
    logic [NUM_FMT-1:0][18:0] fmt;
    logic [7:0] delay;
    logic [7:0] last;
    logic [7:0] ptr;
    logic [7:0] idx;
    logic [3:0] gpioOut;
    logic [3:0] gpioDir;
    logic [8:0] cnt;
    logic [5:0] edgeNo;
    logic [16:0] txSh;
    logic [15:0] rxSh;
    logic [4:0] len;
    logic ph;
    logic pol;
    logic hold;
    logic [7:0] ps;
    logic sclk;
    logic sel;
    logic sclkPrev;
    logic [15:0] rxHold;
    logic rxFull;
    logic ovr;
    apb_rsp_type rsp;
    pin_drive_type pins;
  } state_type;
endpackage

// >>> hdl/buffered_serial_port.sv
// Purpose: buffered serial port, controller or target, with entry memory
// Assumes: pins sampled as synchronous inputs; APB answers with no wait state
// Notes: pin order clk, controller_out_line, controller_in_line, select
// Functional notes
// - words of 2 to 16 bits shift in and out at the set rate
// - bit rate comes from the clock through an 8-bit prescale divider
// - controller makes the serial clock, target takes it from outside
// - each word picks its own format: length, polarity, phase, rate
// - while the port is disabled all four pins serve software as general purpose I/O
// - a 256-entry buffer supplies transmit words and keeps received words
// - each entry holds transmit, receive, control and status halfwords
// - software splits the buffer into groups of consecutive entries
// - controller clock period is prescale plus one, or two for zero
// - polarity sets the idle clock level and thus the active edges
// - a global bit selects controller role, a format bit the phase
// - select to first edge is setup delay plus 2, or 3 with hold
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module buffered_serial_port #(
  parameter int ENTRIES = 256
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire buffered_serial_port_pkg::apb_req_type apbReq,
  output buffered_serial_port_pkg::apb_rsp_type apbRsp,
  input wire logic [3:0] pinIn,
  output buffered_serial_port_pkg::pin_drive_type pinDrive
);
  localparam int IW = $clog2(ENTRIES);
  if (ENTRIES < 2 || ENTRIES > 256 || (ENTRIES & (ENTRIES - 1)) != 0) begin : g_bad_depth
    $error("ENTRIES must be a power of two from 2 to 256");
  end

  buffered_serial_port_pkg::state_type state_q, state_d;
  buffered_serial_port_pkg::entry_type mem [ENTRIES];
  buffered_serial_port_pkg::entry_type cur, memAt;
  logic [18:0] curFmt;
  logic [4:0] curLen;
  logic [7:0] curPs;
  logic curPh;
  logic [8:0] period, hiHalf, loHalf;
  logic [1:0] fmtIdx;
  logic setupPh, wrAcc, rdAcc, tick, inBit, engWr;
  logic [15:0] aligned, rxWord, statWord;

  assign cur = mem[state_q.ptr[IW-1:0]];
  assign memAt = mem[state_q.idx[IW-1:0]];
  assign curFmt = state_q.fmt[cur.ctl[1:0]];
  assign curPs = curFmt[buffered_serial_port_pkg::FMT_PS +: 8];
  assign curPh = curFmt[buffered_serial_port_pkg::FMT_PHASE];
  assign curLen = (curFmt[4:0] < buffered_serial_port_pkg::WORD_MIN) ? buffered_serial_port_pkg::WORD_MIN :
                  (curFmt[4:0] > buffered_serial_port_pkg::WORD_MAX) ? buffered_serial_port_pkg::WORD_MAX :
                  curFmt[4:0];
  // a zero prescale still gives a two-cycle period, never a stuck clock
  assign period = (state_q.ps == 8'h00) ? 9'h002 : {1'b0, state_q.ps} + 9'h001;
  assign hiHalf = period >> 1;
  assign loHalf = period - hiHalf;
  assign fmtIdx = 2'(apbReq.paddr[3:2] - 2'h1);
  assign setupPh = apbReq.psel & ~apbReq.penable;
  assign wrAcc = apbReq.psel & apbReq.penable & state_q.rsp.pready & apbReq.pwrite & ~state_q.rsp.pslverr;
  assign rdAcc = apbReq.psel & apbReq.penable & state_q.rsp.pready & ~apbReq.pwrite;
  assign inBit = state_q.ctrl ? pinIn[buffered_serial_port_pkg::PIN_CIN] :
                 pinIn[buffered_serial_port_pkg::PIN_COUT];
  always_comb begin
    if (state_q.ctrl) begin
      tick = (state_q.st == buffered_serial_port_pkg::SETUP || state_q.st == buffered_serial_port_pkg::SHIFT) &&
             state_q.cnt == 9'h000;
    end else begin
      tick = state_q.st == buffered_serial_port_pkg::SHIFT && !pinIn[buffered_serial_port_pkg::PIN_SEL] &&
             pinIn[buffered_serial_port_pkg::PIN_CLK] != state_q.sclkPrev;
    end
  end
  assign aligned = cur.tx << (5'h10 - curLen);
  assign rxWord = state_q.rxSh & (16'hFFFF >> (5'h10 - state_q.len));
  assign statWord = buffered_serial_port_pkg::STAT_DONE | (state_q.rxFull ? buffered_serial_port_pkg::STAT_OVR : 16'h0000);
  assign engWr = state_q.st == buffered_serial_port_pkg::STORE;

  always_comb begin
    state_d = state_q;
    state_d.rsp.pready = 1'b0;
    state_d.rsp.pslverr = 1'b0;
    state_d.sclkPrev = pinIn[buffered_serial_port_pkg::PIN_CLK];
    // read data is prepared in the setup cycle so it leaves a flop
    if (setupPh) begin
      state_d.rsp.pready = 1'b1;
      state_d.rsp.prdata = 32'h0000_0000;
      if (apbReq.paddr[1:0] != 2'h0) begin
        state_d.rsp.pslverr = 1'b1;
      end else if (apbReq.paddr == buffered_serial_port_pkg::OFS_GLOBAL) begin
        state_d.rsp.prdata = {30'h0000_0000, state_q.en, state_q.ctrl};
      end else if (apbReq.paddr >= buffered_serial_port_pkg::OFS_FMT &&
                   apbReq.paddr < buffered_serial_port_pkg::OFS_DELAY) begin
        state_d.rsp.prdata = {13'h0000, state_q.fmt[fmtIdx]};
      end else if (apbReq.paddr == buffered_serial_port_pkg::OFS_DELAY) begin
        state_d.rsp.prdata = {24'h00_0000, state_q.delay};
      end else if (apbReq.paddr == buffered_serial_port_pkg::OFS_GROUP) begin
        state_d.rsp.prdata = {16'h0000, state_q.last, state_q.ptr};
      end else if (apbReq.paddr == buffered_serial_port_pkg::OFS_BUFIDX) begin
        state_d.rsp.prdata = {24'h00_0000, state_q.idx};
      end else if (apbReq.paddr == buffered_serial_port_pkg::OFS_BUFTX) begin
        state_d.rsp.prdata = {16'h0000, memAt.tx};
      end else if (apbReq.paddr == buffered_serial_port_pkg::OFS_BUFCTL) begin
        state_d.rsp.prdata = {16'h0000, memAt.ctl};
      end else if (apbReq.paddr == buffered_serial_port_pkg::OFS_BUFRX) begin
        state_d.rsp.prdata = {16'h0000, memAt.rx};
      end else if (apbReq.paddr == buffered_serial_port_pkg::OFS_BUFSTAT) begin
        state_d.rsp.prdata = {16'h0000, memAt.stat};
      end else if (apbReq.paddr == buffered_serial_port_pkg::OFS_RXHOLD) begin
        state_d.rsp.prdata = {16'h0000, state_q.rxHold};
      end else if (apbReq.paddr == buffered_serial_port_pkg::OFS_STATUS) begin
        state_d.rsp.prdata = {16'h0000, state_q.ptr, 5'h00, state_q.ovr, state_q.rxFull,
                              state_q.st != buffered_serial_port_pkg::IDLE};
      end else if (apbReq.paddr == buffered_serial_port_pkg::OFS_GPIO) begin
        state_d.rsp.prdata = {20'h0_0000, pinIn, state_q.gpioDir, state_q.gpioOut};
      end else begin
        state_d.rsp.pslverr = 1'b1;
      end
    end
    if (wrAcc) begin
      if (apbReq.paddr == buffered_serial_port_pkg::OFS_GLOBAL) begin
        state_d.ctrl = apbReq.pwdata[buffered_serial_port_pkg::GCR_CTRL];
        state_d.en = apbReq.pwdata[buffered_serial_port_pkg::GCR_EN];
      end else if (apbReq.paddr >= buffered_serial_port_pkg::OFS_FMT &&
                   apbReq.paddr < buffered_serial_port_pkg::OFS_DELAY) begin
        state_d.fmt[fmtIdx] = apbReq.pwdata[18:0];
      end else if (apbReq.paddr == buffered_serial_port_pkg::OFS_DELAY) begin
        state_d.delay = apbReq.pwdata[7:0];
      end else if (apbReq.paddr == buffered_serial_port_pkg::OFS_BUFIDX) begin
        state_d.idx = apbReq.pwdata[7:0];
      end else if (apbReq.paddr == buffered_serial_port_pkg::OFS_STATUS) begin
        if (apbReq.pwdata[buffered_serial_port_pkg::ST_OVR]) begin
          state_d.ovr = 1'b0;
        end
      end else if (apbReq.paddr == buffered_serial_port_pkg::OFS_GPIO) begin
        state_d.gpioOut = apbReq.pwdata[3:0];
        state_d.gpioDir = apbReq.pwdata[7:4];
      end else if (apbReq.paddr == buffered_serial_port_pkg::OFS_GROUP) begin
        // a start while busy or disabled is dropped
        if (apbReq.pwdata[buffered_serial_port_pkg::GRP_GO] && state_q.en &&
            state_q.st == buffered_serial_port_pkg::IDLE) begin
          state_d.ptr = apbReq.pwdata[7:0];
          state_d.last = apbReq.pwdata[buffered_serial_port_pkg::GRP_LAST +: 8];
          state_d.st = buffered_serial_port_pkg::LOAD;
        end
      end
    end
    if (rdAcc && apbReq.paddr == buffered_serial_port_pkg::OFS_RXHOLD) begin
      state_d.rxFull = 1'b0;
    end
    case (state_q.st)
      buffered_serial_port_pkg::LOAD: begin
        state_d.len = curLen;
        state_d.ph = curPh;
        state_d.pol = curFmt[buffered_serial_port_pkg::FMT_POL];
        state_d.hold = curFmt[buffered_serial_port_pkg::FMT_HOLD];
        state_d.ps = curPs;
        // phase 1 parks one spare bit so the first launch edge shows the msb
        state_d.txSh = curPh ? {1'b0, aligned} : {aligned, 1'b0};
        state_d.rxSh = 16'h0000;
        state_d.edgeNo = 6'h00;
        state_d.sclk = curFmt[buffered_serial_port_pkg::FMT_POL];
        if (state_q.ctrl) begin
          state_d.sel = 1'b0;
          state_d.cnt = {1'b0, state_q.delay} - 9'h001 + (curFmt[buffered_serial_port_pkg::FMT_HOLD] ?
                        buffered_serial_port_pkg::SETUP_HOLD : buffered_serial_port_pkg::SETUP_BASE);
          state_d.st = buffered_serial_port_pkg::SETUP;
        end else begin
          state_d.st = buffered_serial_port_pkg::SHIFT;
        end
      end
      buffered_serial_port_pkg::SETUP, buffered_serial_port_pkg::SHIFT: begin
        if (tick) begin
          if (state_q.edgeNo[0] == state_q.ph) begin
            state_d.rxSh = {state_q.rxSh[14:0], inBit};
          end else begin
            state_d.txSh = {state_q.txSh[15:0], 1'b0};
          end
          state_d.edgeNo = state_q.edgeNo + 6'h01;
          state_d.st = (state_q.edgeNo == {state_q.len, 1'b0} - 6'h01) ? buffered_serial_port_pkg::STORE :
                       buffered_serial_port_pkg::SHIFT;
          if (state_q.ctrl) begin
            state_d.sclk = ~state_q.sclk;
            state_d.cnt = (state_q.edgeNo[0] ? loHalf : hiHalf) - 9'h001;
          end
        end else if (state_q.ctrl) begin
          state_d.cnt = state_q.cnt - 9'h001;
        end
      end
      buffered_serial_port_pkg::STORE: begin
        state_d.rxHold = rxWord;
        state_d.rxFull = 1'b1;
        // a clear written in this cycle stands unless this store overruns again
        state_d.ovr = state_d.ovr | state_q.rxFull;
        if (state_q.ptr == state_q.last) begin
          state_d.st = buffered_serial_port_pkg::IDLE;
          state_d.sel = 1'b1;
        end else begin
          state_d.ptr = state_q.ptr + 8'h01;
          state_d.sel = state_q.hold ? state_q.sel : 1'b1;
          state_d.st = buffered_serial_port_pkg::LOAD;
        end
      end
      default: begin
        state_d.sel = 1'b1;
      end
    endcase
    if (!state_d.en) begin
      state_d.st = buffered_serial_port_pkg::IDLE;
      state_d.sel = 1'b1;
    end
    if (!state_d.en) begin
      state_d.pins.out = state_d.gpioOut;
      state_d.pins.oe = state_d.gpioDir;
    end else if (state_d.ctrl) begin
      state_d.pins.out = {state_d.sel, 1'b0, state_d.txSh[16], state_d.sclk};
      state_d.pins.oe = buffered_serial_port_pkg::OE_CTRL;
    end else begin
      // target answers only while selected, one cycle behind the select pin
      state_d.pins.out = {1'b0, state_d.txSh[16], 2'h0};
      state_d.pins.oe = {1'b0, ~pinIn[buffered_serial_port_pkg::PIN_SEL], 2'h0};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= '0;
      state_q.fmt <= {buffered_serial_port_pkg::NUM_FMT{buffered_serial_port_pkg::RST_FMT}};
      state_q.sel <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk) begin
    if (wrAcc && apbReq.paddr == buffered_serial_port_pkg::OFS_BUFTX) begin
      mem[state_q.idx[IW-1:0]].tx <= apbReq.pwdata[15:0];
    end
    if (wrAcc && apbReq.paddr == buffered_serial_port_pkg::OFS_BUFCTL) begin
      mem[state_q.idx[IW-1:0]].ctl <= apbReq.pwdata[15:0];
    end
    if (engWr) begin
      mem[state_q.ptr[IW-1:0]].rx <= rxWord;
      mem[state_q.ptr[IW-1:0]].stat <= statWord;
    end
  end

  assign apbRsp = state_q.rsp;
  assign pinDrive = state_q.pins;

  logic sclkLast_q;
  logic [8:0] gapCnt_q, setupCnt_q;
  logic sclkChange;
  assign sclkChange = state_q.sclk != sclkLast_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclkLast_q <= 1'b0;
      gapCnt_q <= 9'h000;
      setupCnt_q <= 9'h000;
    end else begin
      sclkLast_q <= state_q.sclk;
      gapCnt_q <= sclkChange ? 9'h001 : gapCnt_q + 9'h001;
      setupCnt_q <= (state_q.st == buffered_serial_port_pkg::LOAD) ? 9'h000 :
                    (state_q.st == buffered_serial_port_pkg::SETUP) ? setupCnt_q + 9'h001 : setupCnt_q;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_sclk_edge;
    sclkChange && state_q.ctrl && state_q.en;
  endsequence
  sequence s_last_word;
    state_q.st == buffered_serial_port_pkg::STORE && state_q.ptr == state_q.last;
  endsequence

  a_word_length: assert property (state_q.st == buffered_serial_port_pkg::SHIFT |->
    state_q.len >= 5'h02 && state_q.len <= 5'h10) else $error("word length out of range");
  a_edge_total: assert property (state_q.st == buffered_serial_port_pkg::STORE |->
    state_q.edgeNo == {state_q.len, 1'b0}) else $error("word stored after wrong edge count");
  a_half_period: assert property (s_sclk_edge and state_q.edgeNo >= 6'h02 |->
    gapCnt_q == (state_q.edgeNo[0] ? loHalf : hiHalf)) else $error("serial clock half period wrong");
  a_setup_delay: assert property (s_sclk_edge and state_q.edgeNo == 6'h01 |->
    setupCnt_q == {1'b0, state_q.delay} + (state_q.hold ? 9'h003 : 9'h002)) else $error("select to clock delay wrong");
  a_idle_polarity: assert property (state_q.st == buffered_serial_port_pkg::SETUP |->
    state_q.sclk == state_q.pol && state_q.pins.out[0] == state_q.pol) else $error("clock not at idle level");
  a_role_pins: assert property (state_q.en |->
    state_q.pins.oe[0] == state_q.ctrl && state_q.pins.oe[3] == state_q.ctrl) else $error("clock pin role wrong");
  a_gpio_release: assert property (!state_q.en |->
    state_q.pins.oe == state_q.gpioDir && state_q.pins.out == state_q.gpioOut) else $error("idle pins not software owned");
  a_format_load: assert property (state_q.st == buffered_serial_port_pkg::LOAD |=>
    state_q.ps == $past(curPs) && state_q.ph == $past(curPh)) else $error("word format not taken from entry");
  a_store_entry: assert property (state_q.st == buffered_serial_port_pkg::STORE |=>
    mem[$past(state_q.ptr[IW-1:0])].rx == state_q.rxHold && state_q.rxFull) else $error("received word not stored");
  a_group_walk: assert property (s_last_word |=> state_q.st == buffered_serial_port_pkg::IDLE ##1
    state_q.st == buffered_serial_port_pkg::IDLE || $past(wrAcc)) else $error("group did not end at last entry");
  a_hold_stable: assert property ($changed(state_q.rxHold) |->
    $past(state_q.st) == buffered_serial_port_pkg::STORE) else $error("holding register changed outside store");
endmodule

// >>> dv/serial_target_model.sv
// Purpose: behavioural serial target facing the port in controller role
// Assumes: clock and select come from the port and are sampled on clk
// Notes: reply leaves MSB first from bit 15; half periods must be 2+ clocks
`timescale 1ns/1ps
module serial_target_model (
  input wire logic clk,
  input wire logic sclk,
  input wire logic selN,
  input wire logic mosi,
  input wire logic pol,
  input wire logic ph,
  input wire logic [15:0] reply,
  output logic miso,
  output logic [15:0] got
);
  logic sPrev;
  logic selPrev;
  logic first;
  logic lastBit;
  logic [15:0] sh;
  initial begin
    {sPrev, first, lastBit, sh, got} = '0;
    selPrev = 1'b1;
  end
  always @(posedge clk) begin
    sPrev <= sclk;
    selPrev <= selN;
    if (!selN) begin
      lastBit <= sh[15];
    end
    if (selPrev && !selN) begin
      sh <= reply;
      first <= ph;
      got <= 16'h0000;
    end else if (!selN && sclk !== sPrev) begin
      if ((sclk !== pol) ^ ph) begin
        got <= {got[14:0], mosi};
      end else if (first) begin
        first <= 1'b0;
      end else begin
        sh <= {sh[14:0], 1'b0};
      end
    end
  end
  // released line shows the inverse of its last bit so stale data cannot pass
  assign miso = selN ? ~lastBit : sh[15];
endmodule

// >>> dv/buffered_serial_port_tb.sv
// Purpose: self-checking bench of the buffered serial port
// Assumes: controller traffic, one two-entry group, one word in target role
// Notes: fixed seed; prescale kept at 3 or more so the target keeps up
`timescale 1ns/1ps
module buffered_serial_port_tb;
  logic clk;
  logic rst_n;
  buffered_serial_port_pkg::apb_req_type req;
  buffered_serial_port_pkg::apb_rsp_type rsp;
  buffered_serial_port_pkg::pin_drive_type drv;
  logic [3:0] extB;
  logic [15:0] reply;
  logic [15:0] got;
  logic miso, curPol, curPh, mon, sQ, selQ;
  int nErrors, checked, t0, t2, nE, curP, curD;
  logic [31:0] seed;
  wire logic [3:0] pinLvl;
  assign pinLvl = (drv.oe & drv.out) | (~drv.oe & {extB[3], miso, extB[1:0]});
  buffered_serial_port i_dut (.clk(clk), .rst_n(rst_n), .apbReq(req), .apbRsp(rsp), .pinIn(pinLvl),
    .pinDrive(drv));
  serial_target_model i_peer (.clk(clk), .sclk(pinLvl[0]), .selN(pinLvl[3]), .mosi(pinLvl[1]),
    .pol(curPol), .ph(curPh), .reply(reply), .miso(miso), .got(got));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // received word ends up right aligned, its msb taken first from the reply
  function automatic logic [31:0] expect_rx(input logic [15:0] w, input logic [4:0] n);
    return 32'(w >> (16 - n));
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      nErrors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, nErrors);
    if (nErrors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk);
    while (rsp.pready !== 1'b1);
    r = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
  endtask
  // only the watchdog ends a hung transfer
  task automatic idle_wait();
    logic [31:0] r;
    do rd(buffered_serial_port_pkg::OFS_STATUS, r);
    while (r[0] !== 1'b0);
  endtask
  // bench as controller for the target role: mode 0, four clocks per half
  task automatic target_word(input logic [15:0] o, input int nb, output logic [15:0] w);
    w = 16'h0000;
    extB[3] <= 1'b0;
    extB[1] <= o[nb-1];
    repeat (4) @(posedge clk);
    for (int k = nb - 1; k >= 0; k--) begin
      w = {w[14:0], pinLvl[2]};
      extB[0] <= 1'b1;
      repeat (4) @(posedge clk);
      extB[0] <= 1'b0;
      extB[1] <= (k > 0) ? o[k-1] : 1'b0;
      repeat (4) @(posedge clk);
    end
    extB[3] <= 1'b1;
    @(posedge clk);
  endtask
  // edge timing watched on the pins, reckoned from select falling
  always @(posedge clk) begin
    t0++;
    t2++;
    if (mon && selQ && !drv.out[3]) begin
      t0 = 0;
      nE = 0;
      chk(drv.out[0], curPol);
      chk(drv.oe, buffered_serial_port_pkg::OE_CTRL);
    end else if (mon && !drv.out[3] && drv.out[0] !== sQ) begin
      if (nE == 0) chk(t0, curD);
      if (nE == 0) t2 = 0;
      if (nE == 2) chk(t2, curP);
      nE++;
    end
    sQ <= drv.out[0];
    selQ <= drv.out[3];
  end
  initial begin
    repeat (60000) @(posedge clk);
    nErrors++;
    conclude();
  end
  initial begin
    logic [31:0] r, tx;
    logic e, hold;
    logic [4:0] len;
    logic [7:0] ps, ent;
    logic [15:0] w16;
    int f;
    rst_n = 1'b0;
    req = '0;
    {extB, reply, curPol, curPh, mon, sQ, selQ} = {4'hB, 16'h0000, 5'h00};
    seed = 32'h080c_0b19;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(buffered_serial_port_pkg::OFS_GLOBAL, r);
    chk(r, 32'h0000_0000);
    rd(buffered_serial_port_pkg::OFS_FMT, r);
    chk(r, 32'(buffered_serial_port_pkg::RST_FMT));
    apb(1'b0, 8'h3C, 32'h0000_0000, r, e);
    chk(e, 32'h0000_0001);
    wr(buffered_serial_port_pkg::OFS_GPIO, 32'h0000_00F5);
    rd(buffered_serial_port_pkg::OFS_GPIO, r);
    chk(r, 32'h0000_05F5);
    chk({drv.oe, drv.out}, 32'h0000_00F5);
    wr(buffered_serial_port_pkg::OFS_GPIO, 32'h0000_0000);
    rd(buffered_serial_port_pkg::OFS_GPIO, r);
    chk(r[11:8], pinLvl);
    wr(buffered_serial_port_pkg::OFS_GLOBAL, 32'h0000_0002);
    rd(buffered_serial_port_pkg::OFS_GLOBAL, r);
    chk(r, 32'h0000_0002);
    chk(drv.oe, 32'h0000_0000);
    wr(buffered_serial_port_pkg::OFS_GLOBAL, 32'h0000_0003);
    mon <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      f = i % 4;
      ent = (i == 0) ? 8'hFF : seed[7:0];
      len = (i == 0) ? 5'h02 : (i == 1) ? 5'h10 : 5'(2 + seed[11:8] % 15);
      ps = (i == 2) ? 8'hFF : 8'(3 + seed[15:12] % 13);
      hold = seed[16];
      curPh <= seed[17];
      curPol <= seed[18];
      curP = ps + 1;
      curD = seed[21:19] + (hold ? 3 : 2);
      tx = {16'h0000, seed[31:16]};
      reply <= seed[27:12];
      wr(buffered_serial_port_pkg::OFS_FMT + 8'(4 * f), {13'h0000, hold, seed[18:17], ps, 3'h0, len});
      wr(buffered_serial_port_pkg::OFS_DELAY, {29'h0000_0000, seed[21:19]});
      wr(buffered_serial_port_pkg::OFS_BUFIDX, {24'h00_0000, ent});
      wr(buffered_serial_port_pkg::OFS_BUFTX, tx);
      wr(buffered_serial_port_pkg::OFS_BUFCTL, 32'(f));
      wr(buffered_serial_port_pkg::OFS_GROUP, {16'h8000, ent, ent});
      idle_wait();
      rd(buffered_serial_port_pkg::OFS_BUFRX, r);
      chk(r, expect_rx(reply, len));
      chk(got, tx & (32'h0000_FFFF >> (16 - len)));
      rd(buffered_serial_port_pkg::OFS_BUFSTAT, r);
      chk(r[0], 32'h0000_0001);
      rd(buffered_serial_port_pkg::OFS_STATUS, r);
      chk(r[2:1], (i % 2) ? 32'h0000_0003 : 32'h0000_0001);
      if (i % 2) begin
        rd(buffered_serial_port_pkg::OFS_RXHOLD, r);
        chk(r, expect_rx(reply, len));
        wr(buffered_serial_port_pkg::OFS_STATUS, 32'h0000_0004);
      end
    end
    // two consecutive entries in one group, same rate, different lengths
    curP = 4;
    curD = 2;
    curPol <= 1'b0;
    curPh <= 1'b0;
    reply <= 16'hC3A5;
    wr(buffered_serial_port_pkg::OFS_FMT, 32'h0000_030C);
    wr(buffered_serial_port_pkg::OFS_FMT + 8'h04, 32'h0000_0305);
    wr(buffered_serial_port_pkg::OFS_DELAY, 32'h0000_0000);
    wr(buffered_serial_port_pkg::OFS_BUFIDX, 32'h0000_0040);
    wr(buffered_serial_port_pkg::OFS_BUFTX, 32'h0000_0ABC);
    wr(buffered_serial_port_pkg::OFS_BUFCTL, 32'h0000_0000);
    wr(buffered_serial_port_pkg::OFS_BUFIDX, 32'h0000_0041);
    wr(buffered_serial_port_pkg::OFS_BUFTX, 32'h0000_0013);
    wr(buffered_serial_port_pkg::OFS_BUFCTL, 32'h0000_0001);
    wr(buffered_serial_port_pkg::OFS_GROUP, 32'h8000_4140);
    idle_wait();
    rd(buffered_serial_port_pkg::OFS_GROUP, r);
    chk(r, 32'h0000_4141);
    rd(buffered_serial_port_pkg::OFS_STATUS, r);
    chk(r[2:1], 32'h0000_0003);
    rd(buffered_serial_port_pkg::OFS_RXHOLD, r);
    chk(r, expect_rx(16'hC3A5, 5'h05));
    chk(got, 32'h0000_0013);
    wr(buffered_serial_port_pkg::OFS_BUFIDX, 32'h0000_0040);
    rd(buffered_serial_port_pkg::OFS_BUFRX, r);
    chk(r, expect_rx(16'hC3A5, 5'h0C));
    wr(buffered_serial_port_pkg::OFS_STATUS, 32'h0000_0004);
    // target role: the bench drives clock, select and data in mode 0
    mon <= 1'b0;
    extB <= 4'h8;
    wr(buffered_serial_port_pkg::OFS_GLOBAL, 32'h0000_0002);
    wr(buffered_serial_port_pkg::OFS_FMT, 32'h0000_0008);
    wr(buffered_serial_port_pkg::OFS_BUFIDX, 32'h0000_0020);
    wr(buffered_serial_port_pkg::OFS_BUFTX, 32'h0000_00A5);
    wr(buffered_serial_port_pkg::OFS_BUFCTL, 32'h0000_0000);
    wr(buffered_serial_port_pkg::OFS_GROUP, 32'h8000_2020);
    target_word(16'h003C, 8, w16);
    idle_wait();
    chk(w16, 32'h0000_00A5);
    rd(buffered_serial_port_pkg::OFS_RXHOLD, r);
    chk(r, 32'h0000_003C);
    rd(buffered_serial_port_pkg::OFS_STATUS, r);
    chk(r[2:1], 32'h0000_0000);
    conclude();
  end
endmodule
